// [core/drop_report_pkg.sv]
package drop_report_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;
	localparam int PORT_W = 2;
	localparam int REASON_W = 4;
	localparam int PEND_W = 15;

	// Register indices; the byte address is four times the index.
	localparam logic [13:0] IDX_LEARN_MISS = 14'h185A;
	localparam logic [13:0] IDX_IRQ_MASK = 14'h1880;
	localparam logic [13:0] IDX_IRQ_PEND = 14'h1881;
	localparam logic [15:0] ADDR_LEARN_MISS = {IDX_LEARN_MISS, 2'b00};
	localparam logic [15:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};
	localparam logic [15:0] ADDR_IRQ_PEND = {IDX_IRQ_PEND, 2'b00};

	localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
	localparam logic [31:0] COUNT_MAX = 32'hFFFF_FFFF;
	localparam logic MASK_RESET = 1'b1;
	localparam logic [14:0] PEND_RESET = 15'h0000;

	localparam int MASK_BIT = 0;
	localparam int PEND_BIT = 0;
	localparam int A_VALID_BIT = 1;
	localparam int A_PORT_LSB = 2;
	localparam int A_REASON_LSB = 4;
	localparam int B_VALID_BIT = 8;
	localparam int B_PORT_LSB = 9;
	localparam int B_REASON_LSB = 11;

	localparam logic [1:0] PORT_RESERVED = 2'h3;

	localparam logic [3:0] RSN_TAGGED_ONLY = 4'h0;
	localparam logic [3:0] RSN_FLOOD_SRC_NONMEMBER = 4'h1;
	localparam logic [3:0] RSN_SRC_NOT_FWD = 4'h2;
	localparam logic [3:0] RSN_DST_NOT_FWD = 4'h3;
	localparam logic [3:0] RSN_DST_NONMEMBER = 4'h4;
	localparam logic [3:0] RSN_SRC_NONMEMBER = 4'h5;
	localparam logic [3:0] RSN_UNKNOWN_UCAST = 4'h6;
	localparam logic [3:0] RSN_UNKNOWN_MCAST = 4'h7;
	localparam logic [3:0] RSN_BCAST_THROTTLE = 4'h8;
	localparam logic [3:0] RSN_FLOOD_SRC_NOT_FWD = 4'h9;
	localparam logic [3:0] RSN_SAME_PORT = 4'hA;
	localparam logic [3:0] RSN_ENTRY_FILTER = 4'hB;
	localparam logic [3:0] RSN_VID_ALL_ONES = 4'hE;

	typedef struct packed {
		logic tagged_only_admission;
		logic untagged;
		logic vid_all_ones;
		logic bcast_throttled;
		logic da_found;
		logic da_bcast;
		logic da_mcast;
		logic member_check_en;
		logic admit_non_member;
		logic src_member;
		logic dst_member;
		logic src_fwd;
		logic dst_fwd;
		logic drop_unknown_en;
		logic filter_mcast_en;
		logic same_port;
		logic entry_filter;
	} drop_cond_s;
endpackage : drop_report_pkg

// [core/drop_event_if.sv]
`timescale 1ns/1ns
interface drop_event_if;
	logic drop;
	logic [1:0] drop_port;
	drop_report_pkg::drop_cond_s cond;
	logic evt_valid;
	logic [3:0] evt_reason;
	logic [1:0] evt_port;

	modport enc (
		input drop,
		input drop_port,
		input cond,
		output evt_valid,
		output evt_reason,
		output evt_port
	);
	modport core (
		input evt_valid,
		input evt_reason,
		input evt_port
	);
endinterface : drop_event_if

// [core/drop_reason_encoder.sv]
`timescale 1ns/1ns
module drop_reason_encoder (
	drop_event_if.enc ev
);
	// The checks are taken in a fixed order so that one code is reported
	// even when several conditions hold for the same packet.
	logic [3:0] reason_nxt;
	logic hit_nxt;
	drop_report_pkg::drop_cond_s c;

	assign c = ev.cond;

	always_comb begin
		reason_nxt = drop_report_pkg::RSN_TAGGED_ONLY;
		hit_nxt = 1'b1;
		if (c.tagged_only_admission && c.untagged) begin
			reason_nxt = drop_report_pkg::RSN_TAGGED_ONLY;
		end else if (c.vid_all_ones) begin
			reason_nxt = drop_report_pkg::RSN_VID_ALL_ONES;
		end else if (c.da_bcast && c.bcast_throttled) begin
			reason_nxt = drop_report_pkg::RSN_BCAST_THROTTLE;
		end else if (!c.da_found || c.da_bcast) begin
			if (!c.src_fwd) begin
				reason_nxt = drop_report_pkg::RSN_FLOOD_SRC_NOT_FWD;
			end else if (c.member_check_en && !c.admit_non_member
					&& !c.src_member) begin
				reason_nxt = drop_report_pkg::RSN_FLOOD_SRC_NONMEMBER;
			end else if (!c.da_bcast && !c.da_mcast && c.drop_unknown_en) begin
				reason_nxt = drop_report_pkg::RSN_UNKNOWN_UCAST;
			end else if (c.da_mcast && c.filter_mcast_en) begin
				reason_nxt = drop_report_pkg::RSN_UNKNOWN_MCAST;
			end else begin
				hit_nxt = 1'b0;
			end
		end else if (c.same_port) begin
			reason_nxt = drop_report_pkg::RSN_SAME_PORT;
		end else if (c.entry_filter) begin
			reason_nxt = drop_report_pkg::RSN_ENTRY_FILTER;
		end else if (!c.src_fwd) begin
			reason_nxt = drop_report_pkg::RSN_SRC_NOT_FWD;
		end else if (!c.dst_fwd) begin
			reason_nxt = drop_report_pkg::RSN_DST_NOT_FWD;
		end else if (c.member_check_en && !c.admit_non_member
				&& !c.src_member) begin
			reason_nxt = drop_report_pkg::RSN_SRC_NONMEMBER;
		end else if (c.member_check_en && !c.dst_member) begin
			reason_nxt = drop_report_pkg::RSN_DST_NONMEMBER;
		end else begin
			hit_nxt = 1'b0;
		end
	end

	// A drop with no known cause or a reserved port code is not recorded.
	assign ev.evt_valid = ev.drop && hit_nxt
		&& (ev.drop_port != drop_report_pkg::PORT_RESERVED);
	assign ev.evt_reason = reason_nxt;
	assign ev.evt_port = ev.drop_port;
endmodule : drop_reason_encoder

// [core/switch_drop_event_report.sv]
`timescale 1ns/1ns
module switch_drop_event_report #(
	parameter int COUNT_W = 32
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic learn_miss_p2,
	input wire logic drop,
	input wire logic [1:0] drop_port,
	input wire logic tagged_only_admission,
	input wire logic untagged,
	input wire logic vid_all_ones,
	input wire logic bcast_throttled,
	input wire logic da_found,
	input wire logic da_bcast,
	input wire logic da_mcast,
	input wire logic member_check_en,
	input wire logic admit_non_member,
	input wire logic src_member,
	input wire logic dst_member,
	input wire logic src_fwd,
	input wire logic dst_fwd,
	input wire logic drop_unknown_en,
	input wire logic filter_mcast_en,
	input wire logic same_port,
	input wire logic entry_filter,
	output logic irq
);
	localparam logic [COUNT_W-1:0] CNT_MAX = {COUNT_W{1'b1}};

	drop_event_if ev ();

	logic [COUNT_W-1:0] count_r;
	logic [COUNT_W-1:0] count_nxt;
	logic mask_r;
	logic mask_nxt;
	logic [14:0] pend_r;
	logic [14:0] pend_nxt;
	logic [14:0] pend_base;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic pready_r;
	logic pslverr_r;
	logic irq_r;

	logic access;
	logic take;
	logic done;
	logic hit_count;
	logic hit_mask;
	logic hit_pend;
	logic mapped;
	logic rd_count;
	logic rd_pend;
	logic wr_mask;
	logic a_valid;
	logic b_valid;

	assign ev.drop = drop;
	assign ev.drop_port = drop_port;
	assign ev.cond = '{
		tagged_only_admission: tagged_only_admission,
		untagged: untagged,
		vid_all_ones: vid_all_ones,
		bcast_throttled: bcast_throttled,
		da_found: da_found,
		da_bcast: da_bcast,
		da_mcast: da_mcast,
		member_check_en: member_check_en,
		admit_non_member: admit_non_member,
		src_member: src_member,
		dst_member: dst_member,
		src_fwd: src_fwd,
		dst_fwd: dst_fwd,
		drop_unknown_en: drop_unknown_en,
		filter_mcast_en: filter_mcast_en,
		same_port: same_port,
		entry_filter: entry_filter
	};

	drop_reason_encoder u_enc (
		.ev(ev.enc)
	);

	// Bus decode. Every access gets one wait state. A read clears the count
	// or pending register on the edge that captures the read data, not on
	// the completing edge, so an event landing between the two is not lost.
	assign access = psel && penable;
	assign take = access && !pready_r;
	assign done = access && pready_r;
	assign hit_count = (paddr == drop_report_pkg::ADDR_LEARN_MISS);
	assign hit_mask = (paddr == drop_report_pkg::ADDR_IRQ_MASK);
	assign hit_pend = (paddr == drop_report_pkg::ADDR_IRQ_PEND);
	assign mapped = hit_count || hit_mask || hit_pend;
	assign rd_count = take && !pwrite && hit_count;
	assign rd_pend = take && !pwrite && hit_pend;
	assign wr_mask = done && pwrite && hit_mask && pstrb[0];

	assign a_valid = pend_r[drop_report_pkg::A_VALID_BIT];
	assign b_valid = pend_r[drop_report_pkg::B_VALID_BIT];

	// Counter: a learn miss in the clearing cycle is kept as a count of one.
	always_comb begin
		count_nxt = rd_count ? '0 : count_r;
		if (learn_miss_p2 && (count_nxt != CNT_MAX)) begin
			count_nxt = count_nxt + 1'b1;
		end
	end

	assign mask_nxt = wr_mask ? pwdata[drop_report_pkg::MASK_BIT] : mask_r;

	// The read clear happens first; an event in the same cycle then lands
	// in the emptied set A, so no drop is lost across a read.
	assign pend_base = rd_pend ? drop_report_pkg::PEND_RESET : pend_r;

	always_comb begin
		pend_nxt = pend_base;
		if (ev.evt_valid) begin
			pend_nxt[drop_report_pkg::PEND_BIT] = 1'b1;
			if (!pend_base[drop_report_pkg::A_VALID_BIT]) begin
				pend_nxt[drop_report_pkg::A_VALID_BIT] = 1'b1;
				pend_nxt[drop_report_pkg::A_PORT_LSB +: 2] =
					ev.evt_port;
				pend_nxt[drop_report_pkg::A_REASON_LSB +: 4] =
					ev.evt_reason;
			end else if (!pend_base[drop_report_pkg::B_VALID_BIT]) begin
				pend_nxt[drop_report_pkg::B_VALID_BIT] = 1'b1;
				pend_nxt[drop_report_pkg::B_PORT_LSB +: 2] =
					ev.evt_port;
				pend_nxt[drop_report_pkg::B_REASON_LSB +: 4] =
					ev.evt_reason;
			end
		end
	end

	always_comb begin
		prdata_nxt = 32'h0000_0000;
		if (hit_count) begin
			prdata_nxt[COUNT_W-1:0] = count_r;
		end else if (hit_mask) begin
			prdata_nxt[drop_report_pkg::MASK_BIT] = mask_r;
		end else if (hit_pend) begin
			prdata_nxt[14:0] = pend_r;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			count_r <= drop_report_pkg::COUNT_RESET[COUNT_W-1:0];
			mask_r <= drop_report_pkg::MASK_RESET;
			pend_r <= drop_report_pkg::PEND_RESET;
		end else begin
			count_r <= count_nxt;
			mask_r <= mask_nxt;
			pend_r <= pend_nxt;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			pready_r <= access && !pready_r;
			pslverr_r <= access && !pready_r && !mapped;
			prdata_r <= (access && !pready_r && !pwrite) ? prdata_nxt
				: 32'h0000_0000;
		end
	end

	// The request lags the pending bit by one cycle to keep it a clean flop.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= pend_r[drop_report_pkg::PEND_BIT] && !mask_r;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign irq = irq_r;

	property p_count_inc;
		@(posedge core_clk) disable iff (rst)
		learn_miss_p2 && !rd_count && count_r != CNT_MAX
		|=> count_r == $past(count_r) + 1'b1;
	endproperty
	a_count_inc: assert property (p_count_inc)
		else $error("learn miss count did not advance");

	property p_count_clr;
		@(posedge core_clk) disable iff (rst)
		rd_count && !learn_miss_p2 |=> count_r == '0;
	endproperty
	a_count_clr: assert property (p_count_clr)
		else $error("learn miss count not cleared by read");

	property p_count_sat;
		@(posedge core_clk) disable iff (rst)
		count_r == CNT_MAX && !rd_count |=> count_r == CNT_MAX;
	endproperty
	a_count_sat: assert property (p_count_sat)
		else $error("learn miss count wrapped");

	property p_masked;
		@(posedge core_clk) disable iff (rst)
		mask_r[*2] |=> !irq_r;
	endproperty
	a_masked: assert property (p_masked)
		else $error("interrupt raised while masked");

	property p_irq;
		@(posedge core_clk) disable iff (rst)
		pend_r[drop_report_pkg::PEND_BIT] && !mask_r |=> irq_r;
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt missing while pending and unmasked");

	property p_capture_masked;
		@(posedge core_clk) disable iff (rst)
		mask_r && ev.evt_valid |=> pend_r[drop_report_pkg::PEND_BIT];
	endproperty
	a_capture_masked: assert property (p_capture_masked)
		else $error("drop not captured while masked");

	property p_set_a;
		@(posedge core_clk) disable iff (rst)
		ev.evt_valid && !a_valid && !rd_pend
		|=> a_valid && pend_r[7:4] == $past(ev.evt_reason)
			&& pend_r[3:2] == $past(ev.evt_port);
	endproperty
	a_set_a: assert property (p_set_a)
		else $error("set A not filled from drop event");

	property p_set_b;
		@(posedge core_clk) disable iff (rst)
		ev.evt_valid && a_valid && !b_valid && !rd_pend
		|=> b_valid && pend_r[14:11] == $past(ev.evt_reason)
			&& pend_r[10:9] == $past(ev.evt_port)
			&& pend_r[7:1] == $past(pend_r[7:1]);
	endproperty
	a_set_b: assert property (p_set_b)
		else $error("set B not filled or set A disturbed");

	property p_both_full;
		@(posedge core_clk) disable iff (rst)
		a_valid && b_valid && !rd_pend |=> $stable(pend_r[14:1]);
	endproperty
	a_both_full: assert property (p_both_full)
		else $error("full record sets were overwritten");

	property p_pend_clr;
		@(posedge core_clk) disable iff (rst)
		rd_pend && !ev.evt_valid |=> pend_r == drop_report_pkg::PEND_RESET;
	endproperty
	a_pend_clr: assert property (p_pend_clr)
		else $error("pending register not cleared by read");

	property p_reserved_reason;
		@(posedge core_clk) disable iff (rst)
		ev.evt_valid |-> ev.evt_reason != 4'hC && ev.evt_reason != 4'hD
			&& ev.evt_reason != 4'hF;
	endproperty
	a_reserved_reason: assert property (p_reserved_reason)
		else $error("reserved drop reason reported");

	property p_port_code;
		@(posedge core_clk) disable iff (rst)
		ev.evt_valid |=> pend_r[3:2] != drop_report_pkg::PORT_RESERVED;
	endproperty
	a_port_code: assert property (p_port_code)
		else $error("reserved port code stored");

	property p_count_hold;
		@(posedge core_clk) disable iff (rst)
		!learn_miss_p2 && !rd_count |=> $stable(count_r);
	endproperty
	a_count_hold: assert property (p_count_hold)
		else $error("learn miss count moved without a miss");

	property p_rd_count_data;
		@(posedge core_clk) disable iff (rst)
		rd_count |=> prdata_r[COUNT_W-1:0] == $past(count_r);
	endproperty
	a_rd_count_data: assert property (p_rd_count_data)
		else $error("learn miss read returned a wrong value");

	property p_rd_pend_data;
		@(posedge core_clk) disable iff (rst)
		rd_pend |=> prdata_r[14:0] == $past(pend_r);
	endproperty
	a_rd_pend_data: assert property (p_rd_pend_data)
		else $error("pending read returned a wrong value");

	property p_mask_write;
		@(posedge core_clk) disable iff (rst)
		wr_mask |=> mask_r == $past(pwdata[drop_report_pkg::MASK_BIT]);
	endproperty
	a_mask_write: assert property (p_mask_write)
		else $error("mask bit not written");

	property p_irq_off;
		@(posedge core_clk) disable iff (rst)
		!pend_r[drop_report_pkg::PEND_BIT] |=> !irq_r;
	endproperty
	a_irq_off: assert property (p_irq_off)
		else $error("interrupt raised with nothing pending");

	property p_b_needs_a;
		@(posedge core_clk) disable iff (rst)
		b_valid |-> a_valid && pend_r[drop_report_pkg::PEND_BIT];
	endproperty
	a_b_needs_a: assert property (p_b_needs_a)
		else $error("set B valid without set A and pending");
endmodule : switch_drop_event_report

// [tb/switch_drop_event_report_tb.sv]
`timescale 1ns/1ns
`define CHK(got, exp) begin \
	checks_done++; \
	if ((got) !== (exp)) begin \
		fail_count++; \
		$display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
	end \
end
module switch_drop_event_report_tb;
	localparam int CW = 4;
	logic core_clk, rst, psel, penable, pwrite, pready, pslverr, irq;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, pend;
	logic [3:0] pstrb;
	logic learn_miss_p2, drop;
	logic [1:0] drop_port;
	drop_report_pkg::drop_cond_s cs;
	logic [32:0] exq[$];
	logic [32:0] ev;
	logic [3:0] rl[13] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
		4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hE};
	int fail_count, checks_done, n, seed_dummy;
	logic [1:0] p1, p2;

	// A narrow counter lets saturation be reached in a few cycles.
	switch_drop_event_report #(.COUNT_W(CW)) DUT (
		.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.learn_miss_p2(learn_miss_p2), .drop(drop), .drop_port(drop_port),
		.tagged_only_admission(cs.tagged_only_admission),
		.untagged(cs.untagged), .vid_all_ones(cs.vid_all_ones),
		.bcast_throttled(cs.bcast_throttled), .da_found(cs.da_found),
		.da_bcast(cs.da_bcast), .da_mcast(cs.da_mcast),
		.member_check_en(cs.member_check_en),
		.admit_non_member(cs.admit_non_member),
		.src_member(cs.src_member), .dst_member(cs.dst_member),
		.src_fwd(cs.src_fwd), .dst_fwd(cs.dst_fwd),
		.drop_unknown_en(cs.drop_unknown_en),
		.filter_mcast_en(cs.filter_mcast_en), .same_port(cs.same_port),
		.entry_filter(cs.entry_filter), .irq(irq)
	);

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// Found destination, everything forwarding and member: no cause.
	function automatic drop_report_pkg::drop_cond_s cond_for(logic [3:0] r);
		drop_report_pkg::drop_cond_s c;
		c = '0;
		c.da_found = (r inside {4'h2, 4'h3, 4'h4, 4'h5, 4'hA, 4'hB, 4'hF});
		c.src_fwd = (r != 4'h2 && r != 4'h9);
		c.dst_fwd = (r != 4'h3);
		c.src_member = (r != 4'h1 && r != 4'h5);
		c.dst_member = (r != 4'h4);
		c.member_check_en = (r inside {4'h1, 4'h4, 4'h5});
		c.admit_non_member = (r == 4'h4);
		c.tagged_only_admission = (r == 4'h0);
		c.untagged = (r == 4'h0);
		c.vid_all_ones = (r == 4'hE);
		c.bcast_throttled = (r == 4'h8);
		c.da_bcast = (r == 4'h8);
		c.drop_unknown_en = (r == 4'h6);
		c.da_mcast = (r == 4'h7);
		c.filter_mcast_en = (r == 4'h7);
		c.same_port = (r == 4'hA);
		c.entry_filter = (r == 4'hB);
		return c;
	endfunction : cond_for

	task automatic report_and_stop;
		$display("checks=%0d errors=%0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop

	task automatic apb(logic w, logic [15:0] a, logic [31:0] d,
		logic [3:0] s, logic [32:0] e);
		int k;
		exq.push_back(e);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge core_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) begin
			fail_count++;
			report_and_stop();
		end
	endtask : apb

	task automatic rd(logic [15:0] a, logic [31:0] d);
		apb(1'b0, a, 32'h0000_0000, 4'hF, {1'b0, d});
	endtask : rd

	task automatic drop_evt(logic [3:0] r, logic [1:0] p);
		@(posedge core_clk);
		cs <= cond_for(r);
		drop <= 1'b1;
		drop_port <= p;
		@(posedge core_clk);
		drop <= 1'b0;
		cs <= cond_for(4'hF);
	endtask : drop_evt

	function automatic logic [31:0] rec(logic [3:0] r, logic [1:0] p);
		return {24'h0000_00, r, p, 2'b11};
	endfunction : rec

	always @(posedge core_clk) begin
		if (pready === 1'b1) begin
			ev = exq.pop_front();
			`CHK({pslverr, pwrite ? 32'h0000_0000 : prdata}, ev)
		end
	end

	initial begin
		{psel, penable, pwrite, learn_miss_p2, drop} = '0;
		paddr = '0;
		pwdata = '0;
		pstrb = '0;
		drop_port = '0;
		cs = cond_for(4'hF);
		rst = 1'b1;
		seed_dummy = $urandom(32'h6f56);
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		rd(drop_report_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
		rd(drop_report_pkg::ADDR_LEARN_MISS, 32'h0000_0000);
		rd(drop_report_pkg::ADDR_IRQ_PEND, 32'h0000_0000);
		apb(1'b0, 16'h0010, 32'h0000_0000, 4'hF, {1'b1, 32'h0});
		n = $urandom_range(12, 1);
		for (int i = 0; i < 2; i++) begin
			@(posedge core_clk);
			learn_miss_p2 <= 1'b1;
			repeat (n) @(posedge core_clk);
			learn_miss_p2 <= 1'b0;
			rd(drop_report_pkg::ADDR_LEARN_MISS, (n > 15) ? 15 : n);
			rd(drop_report_pkg::ADDR_LEARN_MISS, 32'h0000_0000);
			n = 20;
		end
		foreach (rl[i]) begin
			p1 = $urandom_range(2, 0);
			drop_evt(rl[i], p1);
			rd(drop_report_pkg::ADDR_IRQ_PEND, rec(rl[i], p1));
		end
		// Refused events: no matching cause, then the reserved port code.
		drop_evt(4'hF, 2'h1);
		drop_evt(4'h6, drop_report_pkg::PORT_RESERVED);
		rd(drop_report_pkg::ADDR_IRQ_PEND, 32'h0000_0000);
		p1 = $urandom_range(2, 0);
		p2 = $urandom_range(2, 0);
		drop_evt(4'hA, p1);
		drop_evt(4'h7, p2);
		drop_evt(4'h1, 2'h0);
		pend = rec(4'hA, p1) | {17'h0, 4'h7, p2, 1'b1, 8'h00};
		rd(drop_report_pkg::ADDR_IRQ_PEND, pend);
		`CHK(irq, 1'b0)
		apb(1'b1, drop_report_pkg::ADDR_IRQ_MASK, 32'h0, 4'h0, 33'h0);
		rd(drop_report_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
		drop_evt(4'h3, 2'h2);
		repeat (3) @(posedge core_clk);
		`CHK(irq, 1'b0)
		apb(1'b1, drop_report_pkg::ADDR_IRQ_MASK, 32'h0, 4'hF, 33'h0);
		repeat (2) @(posedge core_clk);
		`CHK(irq, 1'b1)
		rd(drop_report_pkg::ADDR_IRQ_PEND, rec(4'h3, 2'h2));
		repeat (2) @(posedge core_clk);
		`CHK(irq, 1'b0)
		drop_evt(4'h9, 2'h1);
		repeat (3) @(posedge core_clk);
		`CHK(irq, 1'b1)
		apb(1'b1, drop_report_pkg::ADDR_IRQ_MASK, 32'h1, 4'hF, 33'h0);
		repeat (2) @(posedge core_clk);
		`CHK(irq, 1'b0)
		rd(drop_report_pkg::ADDR_IRQ_PEND, rec(4'h9, 2'h1));
		repeat (3) @(posedge core_clk);
		`CHK(exq.size(), 0)
		report_and_stop();
	end
endmodule : switch_drop_event_report_tb
